// file: rtl/pdeg_pkg.sv
package pdeg_pkg;
  // Register byte addresses
  localparam logic [7:0] PDEG_OFS_D_IN = 8'h00;
  localparam logic [7:0] PDEG_OFS_D_LAT = 8'h04;
  localparam logic [7:0] PDEG_OFS_D_DIR = 8'h08;
  localparam logic [7:0] PDEG_OFS_E_IN = 8'h0C;
  localparam logic [7:0] PDEG_OFS_E_LAT = 8'h10;
  localparam logic [7:0] PDEG_OFS_E_DIR = 8'h14;
  localparam logic [7:0] PDEG_OFS_ANA = 8'h18;
  // Field positions in third port input register
  localparam int PDEG_BIT_D_PU = 7;
  localparam int PDEG_BIT_E_PU = 6;
  // Reset values
  localparam logic [7:0] PDEG_RST_D_LAT = 8'h00;
  localparam logic [7:0] PDEG_RST_D_DIR = 8'hFF;
  localparam logic [2:0] PDEG_RST_E_LAT = 3'h0;
  localparam logic [2:0] PDEG_RST_E_DIR = 3'h7;
  localparam logic [2:0] PDEG_RST_ANA = 3'h0;
  localparam logic PDEG_RST_PU = 1'b0;
  localparam logic [31:0] PDEG_RST_PRDATA = 32'h0000_0000;
  // Override pin window on second port
  localparam int PDEG_OVR_LO = 3;
  localparam int PDEG_OVR_HI = 7;
endpackage : pdeg_pkg

// file: rtl/pdeg_gpio.sv
`timescale 1ns/1ps
module pdeg_gpio #(
  parameter bit LARGE_PKG = 1'b1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Second port pins
  input wire logic [7:0] i_d_pin,
  output logic [7:0] o_d_pin,
  output logic [7:0] o_d_oe,
  output logic [7:0] o_d_pullup,
  // Second port peripheral override, pins 3 to 7
  input wire logic [4:0] i_d_ovr_en,
  input wire logic [4:0] i_d_ovr_oe,
  input wire logic [4:0] i_d_ovr_out,
  // Third port pins
  input wire logic [2:0] i_e_pin,
  output logic [2:0] o_e_pin,
  output logic [2:0] o_e_oe,
  output logic [2:0] o_e_pullup,
  output logic [2:0] o_e_analog
);
  import pdeg_pkg::*;

  logic [7:0] d_lat, next_d_lat, d_dir, next_d_dir;
  logic [2:0] e_lat, next_e_lat, e_dir, next_e_dir, ana, next_ana;
  logic d_pu, next_d_pu, e_pu, next_e_pu;
  logic [31:0] prdata, next_prdata;
  logic wr_en, rd_en, hit;
  logic [7:0] d_oe_gpio;

  function automatic logic pdeg_hit(input logic [7:0] a);
    pdeg_hit = (a == PDEG_OFS_D_IN) || (a == PDEG_OFS_D_LAT) || (a == PDEG_OFS_D_DIR)
      || (a == PDEG_OFS_E_IN) || (a == PDEG_OFS_E_LAT) || (a == PDEG_OFS_E_DIR)
      || (a == PDEG_OFS_ANA);
  endfunction : pdeg_hit

  assign hit = LARGE_PKG && pdeg_hit(i_paddr);
  assign wr_en = i_psel && i_penable && i_pwrite && hit;
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_prdata = prdata;

  always_comb begin
    next_d_lat = d_lat;
    next_d_dir = d_dir;
    next_e_lat = e_lat;
    next_e_dir = e_dir;
    next_ana = ana;
    next_d_pu = d_pu;
    next_e_pu = e_pu;
    if (wr_en) begin
      case (i_paddr)
        PDEG_OFS_D_IN: next_d_lat = i_pwdata[7:0];
        PDEG_OFS_D_LAT: next_d_lat = i_pwdata[7:0];
        PDEG_OFS_D_DIR: next_d_dir = i_pwdata[7:0];
        PDEG_OFS_E_IN: begin
          next_e_lat = i_pwdata[2:0];
          next_e_pu = i_pwdata[PDEG_BIT_E_PU];
          next_d_pu = i_pwdata[PDEG_BIT_D_PU];
        end
        PDEG_OFS_E_LAT: next_e_lat = i_pwdata[2:0];
        PDEG_OFS_E_DIR: next_e_dir = i_pwdata[2:0];
        PDEG_OFS_ANA: next_ana = i_pwdata[2:0];
        default: next_ana = ana;
      endcase
    end
  end

  always_comb begin
    next_prdata = prdata;
    if (rd_en) begin
      next_prdata = 32'h0000_0000;
      if (hit) begin
        case (i_paddr)
          PDEG_OFS_D_IN: next_prdata[7:0] = i_d_pin;
          PDEG_OFS_D_LAT: next_prdata[7:0] = d_lat;
          PDEG_OFS_D_DIR: next_prdata[7:0] = d_dir;
          PDEG_OFS_E_IN: begin
            next_prdata[2:0] = i_e_pin & ana;
            next_prdata[PDEG_BIT_E_PU] = e_pu;
            next_prdata[PDEG_BIT_D_PU] = d_pu;
          end
          PDEG_OFS_E_LAT: next_prdata[2:0] = e_lat;
          PDEG_OFS_E_DIR: next_prdata[2:0] = e_dir;
          PDEG_OFS_ANA: next_prdata[2:0] = ana;
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      d_lat <= PDEG_RST_D_LAT;
      d_dir <= PDEG_RST_D_DIR;
      e_lat <= PDEG_RST_E_LAT;
      e_dir <= PDEG_RST_E_DIR;
      ana <= PDEG_RST_ANA;
      d_pu <= PDEG_RST_PU;
      e_pu <= PDEG_RST_PU;
    end else begin
      d_lat <= next_d_lat;
      d_dir <= next_d_dir;
      e_lat <= next_e_lat;
      e_dir <= next_e_dir;
      ana <= next_ana;
      d_pu <= next_d_pu;
      e_pu <= next_e_pu;
    end
  end

  // Read data register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata <= PDEG_RST_PRDATA;
    end else begin
      prdata <= next_prdata;
    end
  end

  // Pin drive
  always_comb begin
    d_oe_gpio = ~d_dir;
    o_d_pin = d_lat;
    o_d_oe = d_oe_gpio;
    for (int i = PDEG_OVR_LO; i <= PDEG_OVR_HI; i++) begin
      if (i_d_ovr_en[i - PDEG_OVR_LO]) begin
        o_d_oe[i] = i_d_ovr_oe[i - PDEG_OVR_LO];
        o_d_pin[i] = i_d_ovr_out[i - PDEG_OVR_LO];
      end
    end
    if (!LARGE_PKG) begin
      o_d_oe = 8'h00;
    end
  end
  assign o_d_pullup = (LARGE_PKG && d_pu) ? ~o_d_oe : 8'h00;
  assign o_e_pin = e_lat;
  assign o_e_oe = LARGE_PKG ? ~e_dir : 3'h0;
  assign o_e_pullup = (LARGE_PKG && e_pu) ? e_dir : 3'h0;
  assign o_e_analog = ~ana;

  // Checks
  e_drive_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(wr_en && i_paddr == PDEG_OFS_E_DIR)
    |-> o_e_oe == ~$past(i_pwdata[2:0])
  ) else $error("third port drive not following direction");

  e_latch_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(wr_en && (i_paddr == PDEG_OFS_E_LAT || i_paddr == PDEG_OFS_E_IN))
    |-> o_e_pin == $past(i_pwdata[2:0])
  ) else $error("third port pin not from latch");

  e_anaread_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    rd_en && i_paddr == PDEG_OFS_E_IN
    |=> (o_prdata[2:0] & $past(o_e_analog)) == 3'h0
  ) else $error("analog pin read not zero");

  e_unimpl_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    rd_en && i_paddr == PDEG_OFS_E_IN
    |=> o_prdata[5:3] == 3'h0
  ) else $error("unimplemented bits not zero");

  e_pullup_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_e_oe & o_e_pullup) == 3'h0
    && (o_d_oe & o_d_pullup) == 8'h00
  ) else $error("pull-up on while output");

  d_pullup_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !d_pu
    |-> o_d_pullup == 8'h00
  ) else $error("second port pull-up while disabled");

  d_ovr_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    LARGE_PKG && i_d_ovr_en[0]
    |-> o_d_oe[3] == i_d_ovr_oe[0] && o_d_pin[3] == i_d_ovr_out[0]
  ) else $error("override not applied");

  d_ovr_hi_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    LARGE_PKG && i_d_ovr_en[4]
    |-> o_d_oe[7] == i_d_ovr_oe[4] && o_d_pin[7] == i_d_ovr_out[4]
  ) else $error("top override pin not applied");

  lat_rmw_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(wr_en && i_paddr == PDEG_OFS_E_LAT) ##1 (rd_en && i_paddr == PDEG_OFS_E_LAT)
    |=> o_prdata[2:0] == $past(i_pwdata[2:0], 3)
  ) else $error("latch read not latch value");

  d_dir_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(wr_en && i_paddr == PDEG_OFS_D_DIR) && i_d_ovr_en == 5'h00
    |-> o_d_oe == ~$past(i_pwdata[7:0])
  ) else $error("second port drive wrong");

  d_lat_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(wr_en && (i_paddr == PDEG_OFS_D_IN || i_paddr == PDEG_OFS_D_LAT))
    && i_d_ovr_en == 5'h00 |-> o_d_pin == $past(i_pwdata[7:0])
  ) else $error("second port latch not written");

  d_rdpin_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    rd_en && hit && i_paddr == PDEG_OFS_D_IN
    |=> o_prdata == {24'h00_0000, $past(i_d_pin)}
  ) else $error("second port read not pin levels");

  e_pu_en_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(wr_en && i_paddr == PDEG_OFS_E_IN)
    |-> o_e_pullup == ($past(i_pwdata[PDEG_BIT_E_PU]) ? ~o_e_oe : 3'h0)
  ) else $error("third port pull-up enable wrong");

  d_pu_en_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(wr_en && i_paddr == PDEG_OFS_E_IN)
    |-> o_d_pullup == ($past(i_pwdata[PDEG_BIT_D_PU]) ? ~o_d_oe : 8'h00)
  ) else $error("second port pull-up enable wrong");

  ana_wr_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $past(wr_en && i_paddr == PDEG_OFS_ANA)
    |-> o_e_analog == ~$past(i_pwdata[2:0])
  ) else $error("analog select not applied");

  rst_pull_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !$past(i_rst_n)
    |-> o_d_pullup == 8'h00 && o_e_pullup == 3'h0
  ) else $error("pull-ups on after reset");

  rst_pins_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !$past(i_rst_n) && i_d_ovr_en == 5'h00
    |-> o_d_oe == 8'h00 && o_e_oe == 3'h0
  ) else $error("pins driving after reset");

  rst_ana_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !$past(i_rst_n)
    |-> o_e_analog == 3'h7
  ) else $error("third port not analog after reset");

  rd_upper_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    rd_en
    |=> o_prdata[31:8] == 24'h00_0000
  ) else $error("read data upper bits not zero");

  rd_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !rd_en
    |=> $stable(o_prdata)
  ) else $error("read data changed without read");

  small_err_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !LARGE_PKG && i_psel && i_penable
    |-> o_pslverr
  ) else $error("small package access not refused");

  small_oe_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !LARGE_PKG
    |-> o_d_oe == 8'h00 && o_e_oe == 3'h0
  ) else $error("small package pins driving");

  wr_d_c: cover property (@(posedge i_clk) wr_en && i_paddr == PDEG_OFS_D_DIR);
  rd_e_c: cover property (@(posedge i_clk) rd_en && i_paddr == PDEG_OFS_E_IN);
  ovr_c: cover property (@(posedge i_clk) i_d_ovr_en != 5'h00);
  err_c: cover property (@(posedge i_clk) o_pslverr);
  ana_c: cover property (@(posedge i_clk) wr_en && i_paddr == PDEG_OFS_ANA);
endmodule : pdeg_gpio

// file: bench/pdeg_board.sv
`timescale 1ns/1ps
module pdeg_board #(
  parameter int W = 8
) (
  // Clock
  input wire logic i_clk,
  // Device side
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_pullup,
  // Board drive
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_ext_en,
  output logic [W-1:0] o_level
);
  logic tog = 1'b0;
  always @(posedge i_clk) begin
    tog <= ~tog;
  end
  // Wire level: device, board, pull-up, else wandering
  always_comb begin
    for (int k = 0; k < W; k++) begin
      o_level[k] = i_oe[k] ? i_out[k] : i_ext_en[k] ? i_ext[k] : i_pullup[k] ? 1'b1 : tog;
    end
  end
endmodule : pdeg_board

// file: bench/pdeg_gpio_tb_top.sv
`timescale 1ns/1ps
module pdeg_gpio_tb_top;
  import pdeg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] d_lvl, d_pin, d_oe, d_pu, d_ext = 8'h03, d_ext_en = 8'h07;
  logic [4:0] ovr_en = 5'h00, ovr_oe = 5'h00, ovr_out = 5'h00;
  logic [2:0] e_lvl, e_pin, e_oe, e_pu, e_ana, e_ext = 3'h5, e_ext_en = 3'h5;
  logic [31:0] prdata_s, rds;
  logic pslverr_s, errs;
  logic [7:0] d_oe_s;
  logic [2:0] e_oe_s;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #10 clk = ~clk;
  pdeg_gpio dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_d_pin(d_lvl), .o_d_pin(d_pin), .o_d_oe(d_oe),
    .o_d_pullup(d_pu), .i_d_ovr_en(ovr_en), .i_d_ovr_oe(ovr_oe), .i_d_ovr_out(ovr_out),
    .i_e_pin(e_lvl), .o_e_pin(e_pin), .o_e_oe(e_oe), .o_e_pullup(e_pu), .o_e_analog(e_ana));
  pdeg_board #(.W(8)) board_d (.i_clk(clk), .i_out(d_pin), .i_oe(d_oe), .i_pullup(d_pu),
    .i_ext(d_ext), .i_ext_en(d_ext_en), .o_level(d_lvl));
  pdeg_board #(.W(3)) board_e (.i_clk(clk), .i_out(e_pin), .i_oe(e_oe), .i_pullup(e_pu),
    .i_ext(e_ext), .i_ext_en(e_ext_en), .o_level(e_lvl));
  pdeg_gpio #(.LARGE_PKG(1'b0)) dut_small (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata_s), .o_pready(), .o_pslverr(pslverr_s), .i_d_pin(d_lvl), .o_d_pin(),
    .o_d_oe(d_oe_s), .o_d_pullup(), .i_d_ovr_en(ovr_en), .i_d_ovr_oe(ovr_oe),
    .i_d_ovr_out(ovr_out), .i_e_pin(e_lvl), .o_e_pin(), .o_e_oe(e_oe_s), .o_e_pullup(),
    .o_e_analog());
  task complete_run;
    $display("counts: %0d compared, %0d unexpected", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    rds = prdata_s;
    errs = pslverr_s;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rchk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("e_analog", 32'h7, {29'h0, e_ana});
    chk("d_oe", 32'h0, {24'h0, d_oe});
    chk("pullups", 32'h0, {21'h0, d_pu, e_pu});
    rchk("d_lat", PDEG_OFS_D_LAT, 32'h0);
    rchk("d_dir", PDEG_OFS_D_DIR, 32'hFF);
    chk("small_rd", 32'h0, rds);
    chk("small_err", 32'h1, {31'h0, errs});
    rchk("e_dir", PDEG_OFS_E_DIR, 32'h7);
    rchk("e_in", PDEG_OFS_E_IN, 32'h0);
    rchk("analog", PDEG_OFS_ANA, 32'h0);
    $display("test reset done");
    apb(1'b1, PDEG_OFS_D_LAT, 32'hA5);
    apb(1'b1, PDEG_OFS_D_DIR, 32'h07);
    @(negedge clk);
    chk("d_oe", 32'hF8, {24'h0, d_oe});
    chk("d_pin", 32'hA0, {24'h0, d_pin & 8'hF8});
    chk("small_d_oe", 32'h0, {24'h0, d_oe_s});
    rchk("d_in", PDEG_OFS_D_IN, 32'hA3);
    apb(1'b1, PDEG_OFS_D_IN, 32'h5A);
    rchk("d_lat", PDEG_OFS_D_LAT, 32'h5A);
    $display("test second port done");
    apb(1'b1, PDEG_OFS_ANA, 32'h3);
    apb(1'b1, PDEG_OFS_E_DIR, 32'h5);
    apb(1'b1, PDEG_OFS_E_LAT, 32'h2);
    rchk("e_lat_rmw", PDEG_OFS_E_LAT, 32'h2);
    @(negedge clk);
    chk("e_oe", 32'h2, {29'h0, e_oe});
    chk("e_pin", 32'h2, {29'h0, e_pin & e_oe});
    chk("e_analog", 32'h4, {29'h0, e_ana});
    chk("small_e_oe", 32'h0, {29'h0, e_oe_s});
    rchk("e_in", PDEG_OFS_E_IN, 32'h3);
    apb(1'b1, PDEG_OFS_E_IN, 32'hFA);
    rchk("e_in", PDEG_OFS_E_IN, 32'hC3);
    rchk("e_lat", PDEG_OFS_E_LAT, 32'h2);
    chk("e_pu", 32'h5, {29'h0, e_pu});
    chk("d_pu", 32'h07, {24'h0, d_pu});
    $display("test third port done");
    ovr_en <= 5'h1F;
    ovr_oe <= 5'h05;
    ovr_out <= 5'h1F;
    @(negedge clk);
    chk("d_oe", 32'h28, {24'h0, d_oe});
    chk("d_pin", 32'h28, {24'h0, d_pin & 8'h28});
    chk("d_pu", 32'hD7, {24'h0, d_pu});
    rchk("unmapped", 8'h1C, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    $display("test override and refusal done");
    complete_run();
  end
endmodule : pdeg_gpio_tb_top
